//--- pkg/frame_fetch_consts.vh
`ifndef FRAME_FETCH_CONSTS_VH
`define FRAME_FETCH_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_PANEL_OUTPUT_CONTROL 32'h4D000010
`define REG_FRAME_BASE_UPPER 32'h4D000014
`define REG_FRAME_BASE_LOWER 32'h4D000018
`define REG_VIRTUAL_SCREEN_GEOMETRY 32'h4D00001C
`define REG_RED_SHADE_TABLE 32'h4D000020
`define REG_FETCH_CONTROL 32'h4D000060
`define REG_FETCH_STATUS 32'h4D000064
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ZERO32 32'h00000000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_DATA_ENABLE_INVERT 6
`define F_POWER_OUT_INVERT 5
`define F_LINE_END_INVERT 4
`define F_PANEL_POWER_OUT_ENABLE 3
`define F_LINE_END_OUT_ENABLE 2
`define F_BYTE_ORDER_SWAP 1
`define F_HALFWORD_ORDER_SWAP 0
`define F_BANK_HI 29
`define F_BANK_LO 21
`define F_START_HI 20
`define F_START_LO 0
`define F_SKIP_HI 21
`define F_SKIP_LO 11
`define F_WIDTH_HI 10
`define F_WIDTH_LO 0
`define F_VIDEO_OUTPUT_ON 0
`define F_DUAL_SCAN 1
`define F_ACTIVE_MATRIX 2
`define PANEL_CTRL_MASK 32'h0000007F
`define GEOM_MASK 32'h003FFFFF
`define BASE1_MASK 32'h3FFFFFFF
`define BASE2_MASK 32'h001FFFFF
`define FETCH_CTRL_MASK 32'h00000007
`endif

//--- test/frame_fetch_asserts.sv
`include "frame_fetch_consts.vh"
`default_nettype none
module frame_fetch_asserts
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [31:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [31:0] fetch_addr_o,
   input wire logic fetch_req_o,
   input wire logic fetch_ack_i,
   input wire logic pixel_word_valid_o,
   input wire logic line_end_strobe_o,
   input wire logic panel_power_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic [6:0] pc_r;
   logic [8:0] bank_r;
   logic [2:0] fc_r;
   // Shadows, so gated pins can be judged from bus traffic alone
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pc_r <= 7'h00;
         bank_r <= 9'h000;
         fc_r <= 3'h0;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `REG_PANEL_OUTPUT_CONTROL: pc_r <= reg_wdata_i[6:0];
            `REG_FRAME_BASE_UPPER: bank_r <= reg_wdata_i[29:21];
            `REG_FETCH_CONTROL: fc_r <= reg_wdata_i[2:0];
            default: ;
         endcase
      end
   end
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not idle");
   a_take_valid: assert property (fetch_req_o && fetch_ack_i |=> pixel_word_valid_o)
      else $error("no pixel word after take");
   a_idle_valid: assert property (!(fetch_req_o && fetch_ack_i) |=> !pixel_word_valid_o)
      else $error("pixel word without take");
   a_bank_field: assert property (fetch_req_o |-> fetch_addr_o[31:22] == {1'b0, bank_r})
      else $error("bank bits wrong");
   a_power_pin: assert property (1'b1 |=> panel_power_pin_o == $past(pc_r[3] & (fc_r[0] ^ pc_r[5])))
      else $error("power pin wrong");
   a_line_end_off: assert property (!(fc_r[2] && pc_r[2]) |=> !line_end_strobe_o)
      else $error("line end while disabled");
   a_req_gated: assert property (!fc_r[0] |-> !fetch_req_o)
      else $error("fetch while video off");
   a_addr_hold: assert property (fetch_req_o && !fetch_ack_i |=> $stable(fetch_addr_o))
      else $error("address moved while waiting");
endmodule // frame_fetch_asserts
bind lcd_frame_fetch_output_control frame_fetch_asserts u_frame_fetch_asserts (
   .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .fetch_addr_o(fetch_addr_o), .fetch_req_o(fetch_req_o), .fetch_ack_i(fetch_ack_i),
   .pixel_word_valid_o(pixel_word_valid_o), .line_end_strobe_o(line_end_strobe_o),
   .panel_power_pin_o(panel_power_pin_o));
`default_nettype wire

//--- test/frame_mem_model.sv
`default_nettype none
module frame_mem_model
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [3:0] wait_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   output logic ack_o,
   output logic [31:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_r;
   // Off-take cycles show the inverse, so stale data cannot pass
   assign data_o = ack_o ? addr_i ^ 32'hA5C30F96 : ~(addr_i ^ 32'hA5C30F96);
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         cnt_r <= 4'h0;
      end
      else if (ack_o || !req_i)
      begin
         ack_o <= 1'b0;
         cnt_r <= 4'h0;
      end
      else if (cnt_r == wait_i)
         ack_o <= 1'b1;
      else
         cnt_r <= cnt_r + 4'h1;
   end
endmodule // frame_mem_model
`default_nettype wire

//--- test/tb_top.sv
`include "frame_fetch_consts.vh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0] BANK = 9'h0A5;
   logic clk, rst, wr, rd, fs, vr, lr, pv, vo, lo, po, rq, ak;
   logic [31:0] ra, wd, rdat, fa, fd, pw;
   logic [3:0] mw, rs;
   logic [2:0] rc;
   logic [9:0] ll;
   int err_total, cmp_count, cyc;
   logic [31:0] at [6] = '{`REG_PANEL_OUTPUT_CONTROL, `REG_FRAME_BASE_UPPER,
      `REG_FRAME_BASE_LOWER, `REG_VIRTUAL_SCREEN_GEOMETRY, `REG_RED_SHADE_TABLE, `REG_FETCH_CONTROL};
   logic [31:0] mk [6] = '{`PANEL_CTRL_MASK, `BASE1_MASK, `BASE2_MASK, `GEOM_MASK,
      32'hFFFFFFFF, `FETCH_CTRL_MASK};
   lcd_frame_fetch_output_control #(.LINE_BITS(10)) u_lcd_frame_fetch_output_control (
      .mclk_i(clk), .rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdat), .frame_start_i(fs), .last_line_i(ll),
      .fetch_addr_o(fa), .fetch_req_o(rq), .fetch_ack_i(ak), .fetch_data_i(fd),
      .pixel_word_o(pw), .pixel_word_valid_o(pv), .video_data_valid_raw_i(vr),
      .line_end_strobe_raw_i(lr), .red_code_i(rc), .video_data_valid_o(vo),
      .line_end_strobe_o(lo), .panel_power_pin_o(po), .red_shade_o(rs));
   frame_mem_model u_frame_mem_model (.mclk_i(clk), .rst_i(rst), .wait_i(mw), .req_i(rq),
      .addr_i(fa), .ack_o(ak), .data_o(fd));
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] swp(input logic [31:0] d, input logic b, input logic h);
      logic [31:0] t;
      t = b ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      return h ? {t[15:0], t[31:16]} : t;
   endfunction
   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdat, e);
   endtask
   task automatic t_regs;
      for (int k = 0; k < 6; k++)
      begin
         rreg(at[k], 32'h0);
         wreg(at[k], 32'hFFFFFFFF);
         rreg(at[k], mk[k]);
         wreg(at[k], 32'h0);
      end
      wreg(32'h4D000024, 32'hFFFFFFFF);
      rreg(32'h4D000024, 32'h0);
   endtask
   task automatic t_panel;
      logic [6:0] p;
      logic a, v, x;
      wreg(`REG_RED_SHADE_TABLE, 32'h9E3C5A71);
      for (int i = 0; i < 128; i++)
      begin
         {a, p[6:2], v} = 7'(i);
         p[1:0] = 2'h0;
         x = ^i[3:0];
         wreg(`REG_FETCH_CONTROL, {29'h0, a, 1'b0, v});
         wreg(`REG_PANEL_OUTPUT_CONTROL, {25'h0, p});
         @(posedge clk);
         vr <= x;
         lr <= !x;
         rc <= i[5:3];
         @(posedge clk);
         @(negedge clk);
         chk(vo, x ^ (a & p[6]));
         chk(lo, (a & p[2]) ? !x ^ p[4] : 1'b0);
         chk(po, p[3] & (v ^ p[5]));
         chk(rs, a ? 4'h0 : 4'(32'h9E3C5A71 >> (4 * i[5:3])));
      end
      wreg(`REG_FETCH_CONTROL, 32'h0);
   endtask
   task automatic t_frame(input logic dual, input logic [3:0] w, input logic [1:0] sw,
      input logic [20:0] u, input logic [20:0] l);
      logic [20:0] c [2];
      logic [20:0] e;
      logic [31:0] d;
      int n, h, li;
      c = '{u, l};
      n = 0;
      mw <= w;
      wreg(`REG_VIRTUAL_SCREEN_GEOMETRY, {10'h000, 11'h003, 11'h004});
      wreg(`REG_FRAME_BASE_UPPER, {2'h0, BANK, u});
      wreg(`REG_FRAME_BASE_LOWER, {11'h000, l});
      wreg(`REG_PANEL_OUTPUT_CONTROL, {30'h0, sw});
      wreg(`REG_FETCH_CONTROL, {30'h0, dual, 1'b1});
      @(posedge clk);
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      for (int t = 0; t < 300 && n < (dual ? 8 : 4); t++)
      begin
         @(negedge clk);
         if (rq && ak)
         begin
            h = dual ? n / 2 % 2 : 0;
            li = dual ? n / 4 : n / 2;
            d = fd;
            e = 21'(c[h] + li * 6 + n % 2 * 2);
            chk(fa, {1'b0, BANK, e, 1'b0});
            @(negedge clk);
            chk(pw, swp(d, sw[1], sw[0]));
            chk(pv, 1'b1);
            n++;
         end
      end
      repeat (4) @(negedge clk);
      chk(n, dual ? 8 : 4);
      chk(rq, 1'b0);
      // Next frame must start from a start field rewritten between frames
      wreg(`REG_FRAME_BASE_UPPER, {2'h0, BANK, 21'(u + 21'h000040)});
      @(posedge clk);
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      @(negedge clk);
      chk(rq, 1'b1);
      chk(fa, {1'b0, BANK, 21'(u + 21'h000040), 1'b0});
      wreg(`REG_FETCH_CONTROL, 32'h0);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         tally_and_finish;
      end
   end
   initial
   begin
      rst = 1'b1;
      {wr, rd, fs, vr, lr} = 5'h00;
      ra = 32'h0;
      wd = 32'h0;
      rc = 3'h0;
      mw = 4'h0;
      ll = 10'h001;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_panel;
      t_frame(1'b0, 4'h0, 2'h2, 21'h000100, 21'h00010E);
      t_frame(1'b1, 4'h3, 2'h1, 21'h000200, 21'h000400);
      t_frame(1'b0, 4'h1, 2'h3, 21'h000300, 21'h00030E);
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire

//--- verilog/lcd_frame_fetch_output_control.v
//
// Contract
// - Data-valid output inverted when invert bit set in active-matrix mode
// - Power output inverted when invert bit set
// - Line-end strobe inverted when invert bit set
// - Power output driven only when enabled
// - Line-end strobe generated only when enabled and in active-matrix mode
// - Byte swap of fetched data when enabled
// - Half-word swap of fetched data when enabled
// - Bank field forms fetch address bits 30:22
// - Upper counter loads upper start field
// - Dual scan: lower counter loads lower field
// - Single scan: lower field unused; last-line input marks frame end
// - Next frame prefetched before frame boundary
// - Line start adds skip to last half-word
// - Each line fetches viewport-width half-words; an odd width fetches one half-word more
// - Red code selects 4-bit shade nibble on passive panels
//
// Design decision made here: the address-and-strobe port.
`include "frame_fetch_consts.vh"
`default_nettype none
module lcd_frame_fetch_output_control
#(
   parameter LINE_BITS = 10
)
(
   input wire mclk_i,
   input wire rst_i,
   // Register port
   input wire [31:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // Frame timing from the panel timing logic
   input wire frame_start_i,
   input wire [LINE_BITS-1:0] last_line_i,
   // Memory fetch side
   output reg [31:0] fetch_addr_o,
   output wire fetch_req_o,
   input wire fetch_ack_i,
   input wire [31:0] fetch_data_i,
   output reg [31:0] pixel_word_o,
   output reg pixel_word_valid_o,
   // Panel signals in, raw polarity
   input wire video_data_valid_raw_i,
   input wire line_end_strobe_raw_i,
   input wire [2:0] red_code_i,
   // Panel pins
   output reg video_data_valid_o,
   output reg line_end_strobe_o,
   output reg panel_power_pin_o,
   output reg [3:0] red_shade_o
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [31:0] panel_output_control_r;
   reg [31:0] frame_base_upper_r;
   reg [31:0] frame_base_lower_r;
   reg [31:0] virtual_screen_geometry_r;
   reg [31:0] red_shade_table_r;
   reg [31:0] fetch_control_r;

   wire video_output_on = fetch_control_r[`F_VIDEO_OUTPUT_ON];
   wire dual_scan = fetch_control_r[`F_DUAL_SCAN];
   wire active_matrix = fetch_control_r[`F_ACTIVE_MATRIX];
   wire [8:0] frame_bank_bits = frame_base_upper_r[`F_BANK_HI:`F_BANK_LO];
   wire [20:0] upper_start_addr = frame_base_upper_r[`F_START_HI:`F_START_LO];
   wire [20:0] lower_start_addr = frame_base_lower_r[`F_START_HI:`F_START_LO];
   wire [10:0] line_skip_halfwords = virtual_screen_geometry_r[`F_SKIP_HI:`F_SKIP_LO];
   wire [10:0] viewport_width_halfwords =
      virtual_screen_geometry_r[`F_WIDTH_HI:`F_WIDTH_LO];

   // Address-compare helper, used by both write and read decode
   function hit;
      input [31:0] a;
      input [31:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         panel_output_control_r <= `RST_ZERO32;
         frame_base_upper_r <= `RST_ZERO32;
         frame_base_lower_r <= `RST_ZERO32;
         virtual_screen_geometry_r <= `RST_ZERO32;
         red_shade_table_r <= `RST_ZERO32;
         fetch_control_r <= `RST_ZERO32;
      end
      else if (reg_wr_i)
      begin
         // Reserved bits masked, so they always read back as zero
         if (hit(reg_addr_i, `REG_PANEL_OUTPUT_CONTROL))
            panel_output_control_r <= reg_wdata_i & `PANEL_CTRL_MASK;
         if (hit(reg_addr_i, `REG_FRAME_BASE_UPPER))
            frame_base_upper_r <= reg_wdata_i & `BASE1_MASK;
         if (hit(reg_addr_i, `REG_FRAME_BASE_LOWER))
            frame_base_lower_r <= reg_wdata_i & `BASE2_MASK;
         // Geometry is not interlocked; software changes it with video off
         if (hit(reg_addr_i, `REG_VIRTUAL_SCREEN_GEOMETRY))
            virtual_screen_geometry_r <= reg_wdata_i & `GEOM_MASK;
         if (hit(reg_addr_i, `REG_RED_SHADE_TABLE))
            red_shade_table_r <= reg_wdata_i;
         if (hit(reg_addr_i, `REG_FETCH_CONTROL))
            fetch_control_r <= reg_wdata_i & `FETCH_CTRL_MASK;
      end
   end

   // ----------------------------------------
   // Fetch address generation
   // ----------------------------------------
   reg [20:0] upper_cnt_r;
   reg [20:0] lower_cnt_r;
   reg [10:0] col_cnt_r;
   reg [LINE_BITS-1:0] line_cnt_r;
   reg half_sel_r;
   reg frame_done_r;
   reg armed_r;

   // Dual scan alternates one upper line with one lower line
   // Each fetch is one word = two half-words
   wire [20:0] active_cnt = (dual_scan && half_sel_r) ? lower_cnt_r : upper_cnt_r;
   // Width is taken as even; an odd width overruns the line by one half-word
   wire line_last = (col_cnt_r + 11'h002 >= viewport_width_halfwords);
   wire take = fetch_req_o && fetch_ack_i;

   assign fetch_req_o = video_output_on && armed_r && !frame_done_r;

   always @*
   begin
      fetch_addr_o = {1'b0, frame_bank_bits, active_cnt, 1'b0};
   end

   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         upper_cnt_r <= 21'h000000;
         lower_cnt_r <= 21'h000000;
         col_cnt_r <= 11'h000;
         line_cnt_r <= {LINE_BITS{1'b0}};
         half_sel_r <= 1'b0;
         frame_done_r <= 1'b0;
         armed_r <= 1'b0;
      end
      else if (!video_output_on)
      begin
         armed_r <= 1'b0;
         frame_done_r <= 1'b0;
      end
      else if (frame_start_i)
      begin
         // Fields sampled here, so fetch for the next frame ahead of display
         upper_cnt_r <= upper_start_addr;
         // Single scan never walks this counter; frame end comes from last_line_i
         lower_cnt_r <= lower_start_addr;
         col_cnt_r <= 11'h000;
         line_cnt_r <= {LINE_BITS{1'b0}};
         half_sel_r <= 1'b0;
         frame_done_r <= 1'b0;
         armed_r <= 1'b1;
      end
      else if (take)
      begin
         if (line_last)
         begin
            col_cnt_r <= 11'h000;
            // Last half-word of line plus skip gives next line start
            if (dual_scan && half_sel_r)
               lower_cnt_r <= lower_cnt_r + 21'h000001 + {10'h000, line_skip_halfwords};
            else
               upper_cnt_r <= upper_cnt_r + 21'h000001 + {10'h000, line_skip_halfwords};
            if (dual_scan && !half_sel_r)
               half_sel_r <= 1'b1;
            else
            begin
               half_sel_r <= 1'b0;
               line_cnt_r <= line_cnt_r + 1'b1;
               if (line_cnt_r == last_line_i)
                  frame_done_r <= 1'b1;
            end
         end
         else
         begin
            col_cnt_r <= col_cnt_r + 11'h002;
            if (dual_scan && half_sel_r)
               lower_cnt_r <= lower_cnt_r + 21'h000002;
            else
               upper_cnt_r <= upper_cnt_r + 21'h000002;
         end
      end
   end

   // ----------------------------------------
   // Data path
   // ----------------------------------------
   // Swap ahead of the word register, so data and valid leave together
   wire [31:0] swapped_word;

   video_word_swap u_swap
   (
      .data_i(fetch_data_i),
      .byte_order_swap_i(panel_output_control_r[`F_BYTE_ORDER_SWAP]),
      .halfword_order_swap_i(panel_output_control_r[`F_HALFWORD_ORDER_SWAP]),
      .data_o(swapped_word)
   );

   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pixel_word_o <= 32'h00000000;
         pixel_word_valid_o <= 1'b0;
      end
      else
      begin
         pixel_word_valid_o <= take;
         if (take)
            pixel_word_o <= swapped_word;
      end
   end

   // ----------------------------------------
   // Panel outputs
   // ----------------------------------------
   // One register stage on every pin keeps them free of decode glitches
   wire den_inv = panel_output_control_r[`F_DATA_ENABLE_INVERT];
   wire pwr_inv = panel_output_control_r[`F_POWER_OUT_INVERT];
   wire line_end_strobe_inv = panel_output_control_r[`F_LINE_END_INVERT];
   wire pwr_en = panel_output_control_r[`F_PANEL_POWER_OUT_ENABLE];
   wire line_end_strobe_en = panel_output_control_r[`F_LINE_END_OUT_ENABLE];

   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         video_data_valid_o <= 1'b0;
         line_end_strobe_o <= 1'b0;
         panel_power_pin_o <= 1'b0;
         red_shade_o <= 4'h0;
      end
      else
      begin
         video_data_valid_o <= video_data_valid_raw_i ^ (active_matrix & den_inv);
         // Disabled pins rest low regardless of polarity
         panel_power_pin_o <= pwr_en & (video_output_on ^ pwr_inv);
         line_end_strobe_o <= active_matrix & line_end_strobe_en &
            (line_end_strobe_raw_i ^ line_end_strobe_inv);
         // Shade lookup serves passive panels only; active matrix reads zero
         red_shade_o <= active_matrix ? 4'h0 :
            red_shade_table_r[{red_code_i, 2'b00} +: 4];
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   reg [31:0] rd_mux;

   always @*
   begin
      rd_mux = 32'h00000000;
      if (hit(reg_addr_i, `REG_PANEL_OUTPUT_CONTROL))
         rd_mux = panel_output_control_r;
      if (hit(reg_addr_i, `REG_FRAME_BASE_UPPER))
         rd_mux = frame_base_upper_r;
      if (hit(reg_addr_i, `REG_FRAME_BASE_LOWER))
         rd_mux = frame_base_lower_r;
      if (hit(reg_addr_i, `REG_VIRTUAL_SCREEN_GEOMETRY))
         rd_mux = virtual_screen_geometry_r;
      if (hit(reg_addr_i, `REG_RED_SHADE_TABLE))
         rd_mux = red_shade_table_r;
      if (hit(reg_addr_i, `REG_FETCH_CONTROL))
         rd_mux = fetch_control_r;
      // Status view is read only; a write to it is dropped
      if (hit(reg_addr_i, `REG_FETCH_STATUS))
         rd_mux = {upper_cnt_r[9:0], half_sel_r, frame_done_r,
                   armed_r, {9'h000}, {{(10-LINE_BITS){1'b0}}, line_cnt_r}};
   end

   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= 32'h00000000;
      else if (reg_rd_i)
         reg_rdata_o <= rd_mux;
      else
         reg_rdata_o <= 32'h00000000;
   end
endmodule // lcd_frame_fetch_output_control
`default_nettype wire

//--- verilog/video_word_swap.v
`default_nettype none
// ----------------------------------------
// Byte and half-word reorder of fetched data
// ----------------------------------------
module video_word_swap
(
   input wire [31:0] data_i,
   input wire byte_order_swap_i,
   input wire halfword_order_swap_i,
   output wire [31:0] data_o
);
   wire [31:0] byte_stage;
   wire [31:0] half_stage;

   assign byte_stage = byte_order_swap_i ?
      {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]} : data_i;
   assign half_stage = halfword_order_swap_i ?
      {byte_stage[15:0], byte_stage[31:16]} : byte_stage;
   assign data_o = half_stage;
endmodule // video_word_swap
`default_nettype wire
